// ---- hdl/tbip_link_sampler.sv ----
/*
 * Link-domain sampler for one transmit telecom bus channel.
 * Assumes the bus clock comes from the upstream source and keeps running
 * after the channel is disabled, so the synchronised enable can drop; the enable arrives from the system
 * clock and is synchronised here.
 */
`timescale 1ns/100ps
module tbip_link_sampler (
    // Link clock and reset
    input wire logic link_clk_i,
    input wire logic reset_n_i,
    // Enable from the system domain
    input wire logic bus_en_i,
    // Bus pins
    input wire logic [7:0] tx_bus_byte_i,
    input wire logic tx_bus_payload_flag_i,
    input wire logic tx_bus_phase_marker_i,
    // Classified stream, link domain
    output logic [7:0] byte_o,
    output logic valid_o,
    output logic payload_o,
    output logic phase_o,
    output logic phase_tgl_o
);
    logic en_meta_q;
    logic en_q;

    always_ff @(negedge link_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            en_meta_q <= 1'b0;
            en_q <= 1'b0;
        end else begin
            en_meta_q <= bus_en_i;
            en_q <= en_meta_q;
        end
    end

    // Every bus input is taken on the falling edge of its own clock.
    always_ff @(negedge link_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            byte_o <= 8'h00;
            valid_o <= 1'b0;
            payload_o <= 1'b0;
            phase_o <= 1'b0;
        end else begin
            valid_o <= en_q; // R1
            byte_o <= en_q ? tx_bus_byte_i : 8'h00;
            payload_o <= en_q & tx_bus_payload_flag_i; // R2 R4
            phase_o <= en_q & tx_bus_phase_marker_i; // R17
        end
    end

    // A toggle carries each phase marker to the system clock.
    always_ff @(negedge link_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase_tgl_o <= 1'b0;
        end else if (en_q && tx_bus_phase_marker_i) begin
            phase_tgl_o <= ~phase_tgl_o; // R17
        end
    end

endmodule

// ---- hdl/tbip_pkg.sv ----
/*
 * Shared constants for the transmit telecom bus indicator pin block:
 * register offsets, field positions, reset values and framer modes.
 * Assumes an 8-bit register port with a 16-bit address.
 */
package tbip_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FCNT_W = 13;

    // Line interface scan registers, one per bus channel 1 to 3.
    localparam logic [15:0] SCAN_CH1_OFS = 16'h2F81;
    localparam logic [15:0] SCAN_CH2_OFS = 16'h3F81;
    localparam logic [15:0] SCAN_CH3_OFS = 16'h4F81;
    localparam int unsigned SCAN_GP_BIT = 1;

    // Control and status registers.
    localparam logic [15:0] BUS_CTRL_OFS = 16'h0100;
    localparam logic [15:0] FRM8_CTRL_OFS = 16'h0108;
    localparam logic [15:0] FRM9_CTRL_OFS = 16'h0109;
    localparam logic [15:0] EVT_STAT_OFS = 16'h0110;

    localparam logic [3:0] BUS_CTRL_RST = 4'h0;
    localparam logic [4:0] FRM_CTRL_RST = 5'h00;

    // Framer control field positions.
    localparam int unsigned FRM_EN_BIT = 0;
    localparam int unsigned FRM_BYP_BIT = 1;
    localparam int unsigned FRM_MODE_LSB = 2;
    localparam int unsigned FRM_E3_BIT = 4;

    typedef enum logic [1:0] {
        TBIP_MODE_LOOP = 2'h0,
        TBIP_MODE_ASYNC = 2'h1,
        TBIP_MODE_EXT = 2'h2
    } tbip_mode_e;

endpackage

// ---- hdl/tbip_top.sv ----
/*
 * Transmit telecom bus indicator pins: payload flags for bus channels
 * 1 to 3, shared phase marker and tributary frame pulse pins for bus
 * channels 0 and 1 (tributaries 8 and 9), plus their registers.
 * Assumes a 10 MHz system clock, one tributary bit strobe per tributary
 * on that clock, and bus clocks from the upstream source.
 */
// Overview of operation
// R1 - Shared pins act for the bus only while that channel's bus is enabled.
// R2 - Payload flag separates overhead bytes from payload bytes on the bus.
// R3 - Upstream holds payload flag low during overhead bytes, high otherwise.
// R4 - Payload flag is sampled on the falling edge of the channel bus clock.
// R5 - With bus disabled the payload pin is a plain input, no datapath effect.
// R6 - That input level reads at bit 1 of the channel scan register.
// R7 - Upstream pulses the phase marker high in the C1 byte clock.
// R8 - Upstream pulses the phase marker high in the J1 byte clock.
// R9 - Bus channel 0 and 1 marker pins are tributary 8 and 9 frame pins.
// R10 - Frame pulse works only with bus disabled and framer enabled.
// R11 - Loop or local async timing drives the frame pulse pin as output.
// R12 - Output pulse lasts one bit, one bit before each frame's first bit.
// R13 - External mode: outside pulse marks the first bit of each frame.
// R14 - External mode aligns frame generation to the outside pulses.
// R15 - Bypassed framer ignores the pin and leaves it undriven.
// R16 - Upstream bus clock runs at 19.44 MHz when the channel is enabled.
// R17 - Phase marker is sampled on the falling bus clock edge too.
`timescale 1ns/100ps
module tbip_top
    import tbip_pkg::*;
#(
    parameter int unsigned DS3_FRAME_BITS = 4760,
    parameter int unsigned E3_FRAME_BITS = 1536
) (
    // System clock, reset and clock enable
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // Register port
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Transmit telecom bus, channels 0 to 3
    input wire logic [3:0] tx_bus_clock_i,
    input wire logic [31:0] tx_bus_byte_i,
    input wire logic [3:1] tx_bus_payload_flag_i,
    // Classified bus stream, each lane on its own bus clock
    output logic [31:0] tx_bus_byte_o,
    output logic [3:0] tx_bus_valid_o,
    output logic [3:0] tx_bus_payload_o,
    output logic [3:0] tx_bus_overhead_o,
    output logic [3:0] tx_bus_phase_o,
    // Shared phase marker / tributary frame pulse pins 8 and 9
    input wire logic [1:0] tributary_frame_pulse_i,
    output logic [1:0] tributary_frame_pulse_o,
    output logic [1:0] tributary_frame_pulse_oe_o,
    // Tributary bit strobes and frame starts
    input wire logic [1:0] trib_bit_stb_i,
    output logic [1:0] trib_frame_start_o
);
    localparam logic [FCNT_W-1:0] DS3_LAST = FCNT_W'(DS3_FRAME_BITS - 1);
    localparam logic [FCNT_W-1:0] E3_LAST = FCNT_W'(E3_FRAME_BITS - 1);

    logic [3:0] bus_en_q;
    logic [1:0][4:0] frm_ctrl_q;
    logic [1:0] phase_seen_q;
    logic [3:0] lane_payload;
    logic [3:0] lane_phase;
    logic [3:0] phase_tgl;
    logic [3:0] tgl_s1_q;
    logic [3:0] tgl_s2_q;
    logic [3:0] tgl_s3_q;
    logic [3:1] gp_s1_q;
    logic [3:1] gp_s2_q;
    logic [3:1] gp_s3_q;
    logic [3:1] gp_lvl_q;
    logic [1:0] fp_s1_q;
    logic [1:0] fp_s2_q;
    logic [1:0] fp_s3_q;
    logic [1:0] fp_lvl_q;
    logic [1:0] phase_evt;
    logic [7:0] rdata_d;

    assign lane_payload = {tx_bus_payload_flag_i, 1'b1};
    assign lane_phase = {2'b00, tributary_frame_pulse_i};

    // Each bus lane is sampled and classified on its own clock.
    for (genvar c = 0; c < 4; c++) begin : g_lane
        tbip_link_sampler u_sampler (
            .link_clk_i(tx_bus_clock_i[c]),
            .reset_n_i(reset_n_i),
            .bus_en_i(bus_en_q[c]),
            .tx_bus_byte_i(tx_bus_byte_i[8*c +: 8]),
            .tx_bus_payload_flag_i(lane_payload[c]),
            .tx_bus_phase_marker_i(lane_phase[c]),
            .byte_o(tx_bus_byte_o[8*c +: 8]),
            .valid_o(tx_bus_valid_o[c]),
            .payload_o(tx_bus_payload_o[c]),
            .phase_o(tx_bus_phase_o[c]),
            .phase_tgl_o(phase_tgl[c])
        );
        // An overhead byte is any enabled byte with the payload flag low.
        assign tx_bus_overhead_o[c] = tx_bus_valid_o[c] & ~tx_bus_payload_o[c]; // R2
    end

    // Control registers.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_en_q <= BUS_CTRL_RST;
            frm_ctrl_q <= {FRM_CTRL_RST, FRM_CTRL_RST};
        end else if (ce_i && reg_wr_i) begin
            if (reg_addr_i == BUS_CTRL_OFS) begin
                bus_en_q <= reg_wdata_i[3:0];
            end else if (reg_addr_i == FRM8_CTRL_OFS) begin
                frm_ctrl_q[0] <= reg_wdata_i[4:0];
            end else if (reg_addr_i == FRM9_CTRL_OFS) begin
                frm_ctrl_q[1] <= reg_wdata_i[4:0];
            end
        end
    end

    // Phase marker toggles cross into the system clock.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tgl_s1_q <= 4'h0;
            tgl_s2_q <= 4'h0;
            tgl_s3_q <= 4'h0;
        end else if (ce_i) begin
            tgl_s1_q <= phase_tgl;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
        end
    end

    assign phase_evt = tgl_s2_q[1:0] ^ tgl_s3_q[1:0];

    // Sticky phase marker flags, write one to clear; a new marker wins.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase_seen_q <= 2'h0;
        end else if (ce_i) begin
            if (reg_wr_i && reg_addr_i == EVT_STAT_OFS) begin
                phase_seen_q <= (phase_seen_q & ~reg_wdata_i[1:0]) | phase_evt;
            end else begin
                phase_seen_q <= phase_seen_q | phase_evt;
            end
        end
    end

    // General-purpose levels; a change counts once two stages agree.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gp_s1_q <= 3'h0;
            gp_s2_q <= 3'h0;
            gp_s3_q <= 3'h0;
            gp_lvl_q <= 3'h0;
        end else if (ce_i) begin
            gp_s1_q <= tx_bus_payload_flag_i;
            gp_s2_q <= gp_s1_q;
            gp_s3_q <= gp_s2_q;
            for (int i = 1; i < 4; i++) begin
                if (gp_s2_q[i] == gp_s3_q[i]) begin
                    gp_lvl_q[i] <= gp_s3_q[i]; // R5
                end
            end
        end
    end

    // Frame pulse pin levels, same filtering.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fp_s1_q <= 2'h0;
            fp_s2_q <= 2'h0;
            fp_s3_q <= 2'h0;
            fp_lvl_q <= 2'h0;
        end else if (ce_i) begin
            fp_s1_q <= tributary_frame_pulse_i;
            fp_s2_q <= fp_s1_q;
            fp_s3_q <= fp_s2_q;
            for (int i = 0; i < 2; i++) begin
                if (fp_s2_q[i] == fp_s3_q[i]) begin
                    fp_lvl_q[i] <= fp_s3_q[i];
                end
            end
        end
    end

    // Tributary frame generators 8 and 9 on bus channel 0 and 1 pins.
    for (genvar t = 0; t < 2; t++) begin : g_trib
        logic [FCNT_W-1:0] cnt_q;
        logic [FCNT_W-1:0] cnt_d;
        logic [FCNT_W-1:0] last;
        logic pulse_q;
        logic start_q;
        logic active;
        logic drive;
        logic ext;
        tbip_mode_e mode;

        assign mode = tbip_mode_e'(frm_ctrl_q[t][FRM_MODE_LSB +: 2]);
        assign last = frm_ctrl_q[t][FRM_E3_BIT] ? E3_LAST : DS3_LAST;
        assign active = ~bus_en_q[t] & frm_ctrl_q[t][FRM_EN_BIT]
            & ~frm_ctrl_q[t][FRM_BYP_BIT]; // R1 R9 R10 R15
        assign drive = active & (mode == TBIP_MODE_LOOP || mode == TBIP_MODE_ASYNC); // R11
        assign ext = active & (mode == TBIP_MODE_EXT);
        // A count already past the last bit, left by a shorter frame select, wraps at once.
        assign cnt_d = (cnt_q >= last) ? '0 : cnt_q + 1'b1;

        always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                cnt_q <= '0;
                pulse_q <= 1'b0;
                start_q <= 1'b0;
            end else if (ce_i) begin
                start_q <= 1'b0;
                if (!active) begin
                    cnt_q <= '0;
                    pulse_q <= 1'b0;
                end else if (trib_bit_stb_i[t]) begin
                    if (ext && fp_lvl_q[t]) begin
                        // The outside pulse sits on bit 0 of a frame.
                        cnt_q <= '0; // R14
                        start_q <= 1'b1;
                    end else begin
                        cnt_q <= cnt_d;
                        start_q <= (cnt_d == '0);
                    end
                    // High for the bit just before the frame's first bit.
                    pulse_q <= drive && (cnt_d == last); // R12
                end
            end
        end

        assign tributary_frame_pulse_o[t] = pulse_q;
        assign tributary_frame_pulse_oe_o[t] = drive; // R11 R15
        assign trib_frame_start_o[t] = start_q;
    end

    // Read decode; unmapped addresses read zero.
    always_comb begin
        rdata_d = 8'h00;
        if (reg_addr_i == SCAN_CH1_OFS) begin
            rdata_d[SCAN_GP_BIT] = gp_lvl_q[1]; // R6
        end else if (reg_addr_i == SCAN_CH2_OFS) begin
            rdata_d[SCAN_GP_BIT] = gp_lvl_q[2]; // R6
        end else if (reg_addr_i == SCAN_CH3_OFS) begin
            rdata_d[SCAN_GP_BIT] = gp_lvl_q[3]; // R6
        end else if (reg_addr_i == BUS_CTRL_OFS) begin
            rdata_d = {4'h0, bus_en_q};
        end else if (reg_addr_i == FRM8_CTRL_OFS) begin
            rdata_d = {3'h0, frm_ctrl_q[0]};
        end else if (reg_addr_i == FRM9_CTRL_OFS) begin
            rdata_d = {3'h0, frm_ctrl_q[1]};
        end else if (reg_addr_i == EVT_STAT_OFS) begin
            rdata_d = {6'h00, phase_seen_q};
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i) begin
            reg_rdata_o <= reg_rd_i ? rdata_d : 8'h00;
        end
    end

endmodule

// ---- tb/tbip_chk.sv ----
/* Port checker for the indicator pin block.
   Assumes a bind onto tbip_top and running bus clocks. */
`timescale 1ns/100ps
module tbip_chk (
    // Clocks and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] tx_bus_clock_i,
    // Register port
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // Bus lanes
    input wire logic [31:0] tx_bus_byte_i,
    input wire logic [3:1] tx_bus_payload_flag_i,
    input wire logic [31:0] tx_bus_byte_o,
    input wire logic [3:0] tx_bus_valid_o,
    input wire logic [3:0] tx_bus_payload_o,
    input wire logic [3:0] tx_bus_overhead_o,
    input wire logic [3:0] tx_bus_phase_o,
    // Frame pulse pins
    input wire logic [1:0] tributary_frame_pulse_i,
    input wire logic [1:0] tributary_frame_pulse_o,
    input wire logic [1:0] trib_bit_stb_i,
    input wire logic [1:0] trib_frame_start_o
);
    sequence s_pulse_end;
        tributary_frame_pulse_o[0] && trib_bit_stb_i[0];
    endsequence
    chk_ovh_split: assert property (@(negedge tx_bus_clock_i[1]) disable iff (!reset_n_i)
        tx_bus_valid_o[1] |-> tx_bus_overhead_o[1] == !$past(tx_bus_payload_flag_i[1]))
        else $error("overhead");
    chk_rd_quiet: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("read data");
    chk_off_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !tx_bus_valid_o[2] |-> tx_bus_byte_o[23:16] == 8'h00) else $error("idle lane");
    chk_pulse_rise: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(tributary_frame_pulse_o[0]) |-> $past(trib_bit_stb_i[0])) else $error("rise");
    chk_pulse_end: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        s_pulse_end |=> !tributary_frame_pulse_o[0]) else $error("pulse length");
    chk_start_bit: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        trib_frame_start_o[1] |-> $past(trib_bit_stb_i[1]) || $past(trib_bit_stb_i[1], 2))
        else $error("frame start");
    chk_byte_take: assert property (@(negedge tx_bus_clock_i[1]) disable iff (!reset_n_i)
        tx_bus_valid_o[1] |-> tx_bus_byte_o[15:8] == $past(tx_bus_byte_i[15:8]))
        else $error("byte");
    chk_flag_take: assert property (@(negedge tx_bus_clock_i[1]) disable iff (!reset_n_i)
        tx_bus_valid_o[1] |-> tx_bus_payload_o[1] == $past(tx_bus_payload_flag_i[1]))
        else $error("payload");
    chk_phase_take: assert property (@(negedge tx_bus_clock_i[1]) disable iff (!reset_n_i)
        tx_bus_valid_o[1] |-> tx_bus_phase_o[1] == $past(tributary_frame_pulse_i[1]))
        else $error("phase");
endmodule

// ---- tb/tbip_src_model.sv ----
/* Upstream byte source: bus clock, nine-byte rows with three overhead
   bytes, phase marker on two bytes. Assumes enables mirror bus control. */
`timescale 1ns/100ps
module tbip_src_model (
    // Lane enables and idle pin levels
    input wire logic [3:0] en_i,
    input wire logic [3:1] gp_i,
    // Bus pins
    output logic clk_o,
    output logic [31:0] byte_o,
    output logic [3:1] flag_o,
    output logic [1:0] marker_o
);
    logic [3:0] idx = 4'h0;
    // The clock runs free so lanes can drain their sync stages on disable.
    initial begin
        clk_o = 1'b0;
        #7;
        forever #15 clk_o = ~clk_o;
    end
    // Pins move on the rising edge, away from the falling sample edge.
    always @(posedge clk_o) idx <= (idx == 4'h8) ? 4'h0 : idx + 4'h1;
    assign byte_o = {4{4'hA, idx}};
    assign flag_o = (en_i[3:1] & {3{idx > 4'h2}}) | (~en_i[3:1] & gp_i);
    // The first marker sits on the last overhead byte, the second in the payload.
    assign marker_o = en_i[1:0] & {2{idx == 4'h2 || idx == 4'h6}};
endmodule

// ---- tb/testbench.sv ----
/* Self-checking bench for tbip_top with the upstream source model.
   Assumes a 10 MHz system clock and shortened frame lengths. */
`timescale 1ns/100ps
module testbench;
    import tbip_pkg::*;
    localparam int unsigned DS3_BITS = 16;
    localparam int unsigned E3_BITS = 8;
    logic clk_i, reset_n_i, reg_wr_i, reg_rd_i, bus_clk;
    logic [15:0] reg_addr_i, f, n;
    logic [7:0] reg_wdata_i, reg_rdata_o;
    logic [31:0] bus_byte, byte_o;
    logic [3:1] flag, gp;
    logic [1:0] marker, ext_fp, pin, fp_o, fp_oe, stb, start, scnt;
    logic [3:0] bus_en, valid_o, pl_o, ovh_o, ph_o;
    int mismatches, samples_checked, k;
    assign pin = (fp_oe & fp_o) | (~fp_oe & (marker | ext_fp));
    tbip_top #(.DS3_FRAME_BITS(DS3_BITS), .E3_FRAME_BITS(E3_BITS)) i_tbip_top (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .tx_bus_clock_i({4{bus_clk}}), .tx_bus_byte_i(bus_byte),
        .tx_bus_payload_flag_i(flag), .tx_bus_byte_o(byte_o), .tx_bus_valid_o(valid_o),
        .tx_bus_payload_o(pl_o), .tx_bus_overhead_o(ovh_o), .tx_bus_phase_o(ph_o),
        .tributary_frame_pulse_i(pin), .tributary_frame_pulse_o(fp_o),
        .tributary_frame_pulse_oe_o(fp_oe), .trib_bit_stb_i(stb),
        .trib_frame_start_o(start));
    tbip_src_model i_tbip_src_model (.en_i(bus_en), .gp_i(gp), .clk_o(bus_clk),
        .byte_o(bus_byte), .flag_o(flag), .marker_o(marker));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // One tributary bit every four system clocks.
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            scnt <= 2'h0;
            stb <= 2'h0;
        end else begin
            scnt <= scnt + 2'h1;
            stb <= {2{scnt == 2'h3}};
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_i);
        cmp(reg_rdata_o & m, e);
    endtask
    // Skips to one frame start, then counts cycles to the next.
    task automatic gap(input int t);
        f = 0;
        while (start[t] !== 1'b1 && f < 300) begin
            @(negedge clk_i);
            f++;
        end
        if (f >= 300) begin
            mismatches++;
        end
        @(negedge clk_i);
        n = 1;
        while (start[t] !== 1'b1 && n < 300) begin
            @(negedge clk_i);
            n++;
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        mismatches++;
        summarize();
    end
    initial begin
        reset_n_i = 1'b0;
        {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, bus_en, ext_fp} = '0;
        gp = 3'h5;
        mismatches = 0;
        samples_checked = 0;
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rdc(BUS_CTRL_OFS, 8'hFF, {4'h0, BUS_CTRL_RST});
        rdc(FRM8_CTRL_OFS, 8'hFF, {3'h0, FRM_CTRL_RST});
        rdc(FRM9_CTRL_OFS, 8'hFF, {3'h0, FRM_CTRL_RST});
        rdc(EVT_STAT_OFS, 8'hFF, 8'h00);
        rdc(16'h0200, 8'hFF, 8'h00);
        $display("reset values done");
        for (k = 0; k < 2; k++) begin
            @(posedge clk_i);
            gp <= (k == 0) ? 3'h5 : 3'h2;
            repeat (8) @(posedge clk_i);
            wr(SCAN_CH1_OFS, 8'hFF);
            rdc(SCAN_CH1_OFS, 8'h02, {6'h0, gp[1], 1'b0});
            rdc(SCAN_CH2_OFS, 8'h02, {6'h0, gp[2], 1'b0});
            rdc(SCAN_CH3_OFS, 8'h02, {6'h0, gp[3], 1'b0});
        end
        $display("scan inputs done");
        for (k = 0; k < 4; k++) begin
            wr(FRM8_CTRL_OFS, {4'h0, k[1:0], 2'h1});
            @(negedge clk_i);
            cmp(fp_oe[0], k < 2);
        end
        wr(FRM8_CTRL_OFS, 8'h03);
        @(negedge clk_i);
        cmp(fp_oe[0], 1'b0);
        wr(FRM8_CTRL_OFS, 8'h01);
        gap(0);
        cmp(n, DS3_BITS * 4);
        while (fp_o[0] !== 1'b1 && f < 400) begin
            @(negedge clk_i);
            f++;
        end
        for (n = 0; fp_o[0] === 1'b1 && n < 300; n++) @(negedge clk_i);
        cmp(n, 4);
        cmp(start[0], 1'b1);
        wr(FRM8_CTRL_OFS, 8'h11);
        gap(0);
        cmp(n, E3_BITS * 4);
        $display("frame output done");
        @(posedge clk_i);
        bus_en <= 4'hF;
        wr(BUS_CTRL_OFS, 8'h0F);
        @(negedge clk_i);
        cmp(fp_oe[0], 1'b0);
        repeat (20) @(posedge clk_i);
        @(negedge clk_i);
        cmp(valid_o, 4'hF);
        rdc(EVT_STAT_OFS, 8'hFF, 8'h03);
        @(posedge clk_i);
        bus_en <= 4'h0;
        wr(BUS_CTRL_OFS, 8'h00);
        repeat (20) @(posedge clk_i);
        @(negedge clk_i);
        cmp({valid_o, byte_o[27:0]}, 32'h0);
        wr(EVT_STAT_OFS, 8'h03);
        rdc(EVT_STAT_OFS, 8'hFF, 8'h00);
        $display("bus lanes done");
        wr(FRM9_CTRL_OFS, 8'h09);
        @(negedge clk_i);
        cmp(fp_oe[1], 1'b0);
        repeat (20) @(posedge clk_i);
        for (k = 0; stb[1] !== 1'b1 && k < 8; k++) @(negedge clk_i);
        @(posedge clk_i);
        ext_fp <= 2'h2;
        repeat (4) @(posedge clk_i);
        ext_fp <= 2'h0;
        gap(1);
        cmp(f < 8, 1'b1);
        cmp(n, DS3_BITS * 4);
        $display("frame input done");
        summarize();
    end
endmodule
bind tbip_top tbip_chk i_tbip_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .tx_bus_clock_i(tx_bus_clock_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .tx_bus_byte_i(tx_bus_byte_i), .tx_bus_payload_flag_i(tx_bus_payload_flag_i),
    .tx_bus_byte_o(tx_bus_byte_o), .tx_bus_valid_o(tx_bus_valid_o),
    .tx_bus_payload_o(tx_bus_payload_o), .tx_bus_overhead_o(tx_bus_overhead_o),
    .tx_bus_phase_o(tx_bus_phase_o), .tributary_frame_pulse_i(tributary_frame_pulse_i),
    .tributary_frame_pulse_o(tributary_frame_pulse_o), .trib_bit_stb_i(trib_bit_stb_i),
    .trib_frame_start_o(trib_frame_start_o));
